/* include/ddr_burst2_defines.svh */
// constants for the burst-of-two double-data-rate sram port
// assumes inclusion by bare name from include/
`ifndef DDR_BURST2_DEFINES_SVH
`define DDR_BURST2_DEFINES_SVH

`define DBP_DATA_W      36
`define DBP_ADDR_W      21
`define DBP_LANE_W      9
`define DBP_LAT_PLL_ON  2
`define DBP_LAT_PLL_OFF 1
`define DBP_BUF_DEPTH   2

`endif

/* include/ddr_burst2_pkg.sv */
// types for the burst-of-two double-data-rate sram port
// assumes nothing beyond a systemverilog compiler
package ddr_burst2_pkg;

	typedef enum logic [2:0] {
		WR_IDLE    = 3'h1,
		WR_WAIT_LO = 3'h2,
		WR_WAIT_HI = 3'h4
	} wr_state_e;

endpackage

/* core/ddr_burst2_sram_port.sv */
// pin-level core of a burst-of-two double-data-rate sram
// assumes k_in/k_n_in and all pins are asynchronous to clk_in and much slower
`timescale 1ns/10ps
`default_nettype none
`include "ddr_burst2_defines.svh"

// Notes on behaviour
// - write beats are taken at a complementary-clock rise and the following true-clock rise.
// - read words launch at a true-clock rise and the following complementary rise.
// - data outputs release on their own whenever no read word is due.
// - data width 18 or 36, two arrays, one per burst word.
// - every access moves exactly two words for one loaded address.
// - byte selects are sampled with each write beat.
// - a lane whose select is high keeps its stored byte.
// - select n governs bits 9n+8 down to 9n.
// - address is sampled at the true-clock rise, shared by reads and writes.
// - with cycle select low, direction high reads and low writes.
// - valid flag marks driven read data and moves only at rises of the true echo strobe.
// - accesses start only at true-clock rises.
// - pll on: first word two true rises later; pll off: one.
// - echo strobes follow the input clocks at all times from three clocks after reset release.
module ddr_burst2_sram_port #(
	parameter int DATA_W    = `DBP_DATA_W,
	parameter int ADDR_W    = `DBP_ADDR_W,
	parameter int LANES     = DATA_W / `DBP_LANE_W,
	parameter int BUF_DEPTH = `DBP_BUF_DEPTH
) (
	input  wire logic              clk_in,
	input  wire logic              rst_b_in,
	input  wire logic              k_in,
	input  wire logic              k_n_in,
	input  wire logic              cycle_select_n_in,
	input  wire logic              read_not_write_in,
	input  wire logic              pll_disable_n_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [LANES-1:0]  byte_write_sel_n_in,
	input  wire logic [DATA_W-1:0] dq_in,
	output logic      [DATA_W-1:0] dq_out,
	output logic                   dq_oe_n_out,
	output logic                   out_valid_flag_out,
	output logic                   echo_strobe_out,
	output logic                   echo_strobe_n_out,
	output logic                   wbuf_ready_out
);
	import ddr_burst2_pkg::*;

	localparam int LW = `DBP_LANE_W;
	localparam int LAT_ON = `DBP_LAT_PLL_ON;
	localparam int LAT_OFF = `DBP_LAT_PLL_OFF;
	localparam int SW = 5 + ADDR_W + LANES + DATA_W;
	localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

	logic [SW-1:0]     pin_s1;
	logic [SW-1:0]     pin_s2;
	logic              k_s;
	logic              kn_s;
	logic              cs_n_s;
	logic              rnw_s;
	logic              pll_on;
	logic [ADDR_W-1:0] addr_s;
	logic [LANES-1:0]  lane_sel_n_s;
	logic [DATA_W-1:0] dq_s;
	logic              k_prev;
	logic              kn_prev;
	logic              k_rise;
	logic              kn_rise;
	logic              cmd_rd;
	logic              cmd_wr;

	// every pin goes through the same two stages so data stays aligned to its clock edge
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_s1  <= '0;
			pin_s2  <= '0;
			k_prev  <= 1'b0;
			kn_prev <= 1'b0;
		end else begin
			pin_s1  <= {k_in, k_n_in, cycle_select_n_in, read_not_write_in, pll_disable_n_in,
				addr_in, byte_write_sel_n_in, dq_in};
			pin_s2  <= pin_s1;
			k_prev  <= k_s;
			kn_prev <= kn_s;
		end
	end

	assign {k_s, kn_s, cs_n_s, rnw_s, pll_on, addr_s, lane_sel_n_s, dq_s} = pin_s2;
	assign k_rise  = k_s & ~k_prev;
	assign kn_rise = kn_s & ~kn_prev;
	assign cmd_rd  = k_rise & ~cs_n_s & rnw_s;
	assign cmd_wr  = k_rise & ~cs_n_s & ~rnw_s;

	// read address pipeline, one step per true-clock rise
	logic [LAT_ON-1:0] rd_v;
	logic [ADDR_W-1:0] rd_a [LAT_ON];
	logic              launch;
	logic [ADDR_W-1:0] launch_a;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_v <= '0;
			for (int i = 0; i < LAT_ON; i++) begin
				rd_a[i] <= '0;
			end
		end else if (k_rise) begin
			rd_v[0] <= cmd_rd;
			rd_a[0] <= addr_s;
			for (int i = 1; i < LAT_ON; i++) begin
				rd_v[i] <= rd_v[i-1];
				rd_a[i] <= rd_a[i-1];
			end
		end
	end

	assign launch   = k_rise & (pll_on ? rd_v[LAT_ON-1] : rd_v[LAT_OFF-1]);
	assign launch_a = pll_on ? rd_a[LAT_ON-1] : rd_a[LAT_OFF-1];

	// two arrays, array 0 holds the first burst word, array 1 the second
	logic [DATA_W-1:0] mem0 [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] mem1 [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] word1;
	logic              word1_pend;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dq_out             <= '0;
			dq_oe_n_out        <= 1'b1;
			out_valid_flag_out <= 1'b0;
			word1              <= '0;
			word1_pend         <= 1'b0;
		end else if (launch) begin
			dq_out             <= mem0[launch_a];
			word1              <= mem1[launch_a];
			word1_pend         <= 1'b1;
			dq_oe_n_out        <= 1'b0;
			out_valid_flag_out <= 1'b1;
		end else if (k_rise) begin
			dq_oe_n_out        <= 1'b1;
			out_valid_flag_out <= 1'b0;
			word1_pend         <= 1'b0;
		end else if (kn_rise && word1_pend) begin
			dq_out     <= word1;
			word1_pend <= 1'b0;
		end
	end

	// echo strobes sit on the same register stage as the data launch
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			echo_strobe_out   <= 1'b0;
			echo_strobe_n_out <= 1'b0;
		end else begin
			echo_strobe_out   <= k_s;
			echo_strobe_n_out <= kn_s;
		end
	end

	// write burst: first beat at the next complementary rise, second at the next true rise
	wr_state_e         wr_st;
	logic [ADDR_W-1:0] wr_a;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_st <= WR_IDLE;
			wr_a  <= '0;
		end else begin
			case (wr_st)
				WR_IDLE: begin
					if (cmd_wr) begin
						wr_st <= WR_WAIT_LO;
						wr_a  <= addr_s;
					end
				end
				WR_WAIT_LO: begin
					if (cmd_wr) begin
						wr_a <= addr_s;
					end else if (kn_rise) begin
						wr_st <= WR_WAIT_HI;
					end
				end
				WR_WAIT_HI: begin
					if (cmd_wr) begin
						wr_st <= WR_WAIT_LO;
						wr_a  <= addr_s;
					end else if (k_rise) begin
						wr_st <= WR_IDLE;
					end
				end
				default: wr_st <= WR_IDLE;
			endcase
		end
	end

	// beat buffer between pin capture and the arrays; reads stall the drain
	logic              fill_req;
	logic              fill_ok;
	logic              push;
	logic              pop;
	logic [PW-1:0]     wp;
	logic [PW-1:0]     rp;
	logic [PW:0]       cnt;
	logic              buf_arr  [BUF_DEPTH];
	logic [ADDR_W-1:0] buf_addr [BUF_DEPTH];
	logic [DATA_W-1:0] buf_data [BUF_DEPTH];
	logic [LANES-1:0]  buf_mask [BUF_DEPTH];

	assign fill_req = (kn_rise && wr_st == WR_WAIT_LO) || (k_rise && wr_st == WR_WAIT_HI);
	assign fill_ok  = cnt != (PW+1)'(BUF_DEPTH);
	assign push     = fill_req & fill_ok;
	assign pop      = (cnt != '0) & ~launch;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wp             <= '0;
			rp             <= '0;
			cnt            <= '0;
			wbuf_ready_out <= 1'b1;
		end else begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
			if (push && !pop) begin
				cnt <= cnt + 1'b1;
			end else if (pop && !push) begin
				cnt <= cnt - 1'b1;
			end
			wbuf_ready_out <= fill_ok;
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			buf_arr[wp]  <= (wr_st == WR_WAIT_HI);
			buf_addr[wp] <= wr_a;
			buf_data[wp] <= dq_s;
			buf_mask[wp] <= lane_sel_n_s;
		end
	end

	always_ff @(posedge clk_in) begin
		if (pop) begin
			for (int l = 0; l < LANES; l++) begin
				if (!buf_mask[rp][l]) begin
					if (buf_arr[rp]) begin
						mem1[buf_addr[rp]][l*LW +: LW] <= buf_data[rp][l*LW +: LW];
					end else begin
						mem0[buf_addr[rp]][l*LW +: LW] <= buf_data[rp][l*LW +: LW];
					end
				end
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_launch;
		launch;
	endsequence
	sequence s_second_word;
		kn_rise && word1_pend && !k_rise;
	endsequence

	// the sync stages are cleared by reset, so the echo only tracks three clocks after release
	a_echo_follow: assert property ($past(rst_b_in, 3) |-> echo_strobe_out == $past(k_in, 3))
		else $error("echo strobe does not follow true clock");
	a_valid_align: assert property ($changed(out_valid_flag_out) |-> $rose(echo_strobe_out))
		else $error("valid flag moves off the echo strobe edge");
	a_launch_drive: assert property (s_launch |=> !dq_oe_n_out && out_valid_flag_out)
		else $error("read word not driven after launch");
	a_second_word: assert property (s_second_word |=> dq_out == $past(word1) && !dq_oe_n_out)
		else $error("second read word missing");
	a_idle_release: assert property (k_rise && !launch |=> dq_oe_n_out && !out_valid_flag_out)
		else $error("bus still driven with no read due");
	a_valid_oe: assert property (out_valid_flag_out == !dq_oe_n_out)
		else $error("valid flag disagrees with drive");
	a_latency_on: assert property (k_rise && pll_on && rd_v[1] |-> launch)
		else $error("pll-on latency not met");
	a_latency_off: assert property (k_rise && !pll_on && rd_v[0] |-> launch)
		else $error("pll-off latency not met");
	a_addr_load: assert property (cmd_rd |=> rd_v[0] && rd_a[0] == $past(addr_s))
		else $error("read address not loaded");
	a_write_seq: assert property (cmd_wr |=> wr_st == WR_WAIT_LO && wr_a == $past(addr_s))
		else $error("write not armed");
	a_beat_push: assert property (kn_rise && wr_st == WR_WAIT_LO && fill_ok |=> cnt != '0)
		else $error("write beat lost");
	a_drain_stall: assert property (launch |-> !pop)
		else $error("drain not stalled by read");

endmodule
`default_nettype wire

/* tb/dbp_ctrl_model.sv */
// controller model: derives k/k_n from clk_in and runs one k period per cycle call
// assumes clk_in at eight times the k rate and the sram port core on the far side
`timescale 1ns/10ps
`default_nettype none
module dbp_ctrl_model (
	input  wire logic        clk_in,
	input  wire logic [35:0] q_in,
	input  wire logic        q_oe_n_in,
	output logic             k_out,
	output logic             k_n_out,
	output logic             sel_n_out,
	output logic             rnw_out,
	output logic [7:0]       addr_out,
	output logic [3:0]       lane_sel_n_out,
	output logic [35:0]      dq_out
);
	logic [2:0]  ph;
	logic [35:0] wd;
	logic        drv;
	logic [35:0] p_wd;
	logic [3:0]  p_bw;
	logic        p_drv;
	logic [2:0]  next_ph;
	initial begin
		ph = 3'h0;
		k_out = 1'h0;
		k_n_out = 1'h1;
		sel_n_out = 1'h1;
		rnw_out = 1'h1;
		addr_out = 8'h0;
		lane_sel_n_out = 4'hf;
		wd = 36'h0;
		drv = 1'h0;
		p_drv = 1'h0;
		p_wd = 36'h0;
		p_bw = 4'hf;
	end
	assign next_ph = ph + 3'h1;
	always @(posedge clk_in) begin
		ph <= next_ph;
		k_out <= ~next_ph[2];
		k_n_out <= next_ph[2];
	end
	// released bus shows the inverse of the last word; contention shows unknown
	assign dq_out = !q_oe_n_in ? (drv ? {36{1'bx}} : q_in) : (drv ? wd : ~wd);
	task automatic at_ph(input logic [2:0] p);
		do @(posedge clk_in); while (ph !== p);
	endtask
	// controls change two clk away from every k and k_n edge
	task automatic cycle(input logic go, rd, input logic [7:0] a, input logic [35:0] w0, w1,
		input logic [3:0] b0, b1);
		at_ph(3'h5);
		sel_n_out <= ~go;
		rnw_out <= rd;
		addr_out <= a;
		wd <= p_wd;
		lane_sel_n_out <= p_bw;
		drv <= p_drv;
		at_ph(3'h1);
		sel_n_out <= 1'h1;
		wd <= w0;
		lane_sel_n_out <= b0;
		drv <= go & ~rd;
		p_wd <= w1;
		p_bw <= b1;
		p_drv <= go & ~rd;
	endtask
	task automatic idle;
		cycle(1'h0, 1'h0, 8'h0, 36'h0, 36'h0, 4'hf, 4'hf);
	endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the burst-of-two sram port core
// assumes the controller model dbp_ctrl_model on the far side
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam logic [35:0] A0 = 36'h3c5a3c5a3;
	localparam logic [35:0] A1 = 36'h5a3c5a3c5;
	logic        clk_in = 1'h0;
	logic        rst_b_in = 1'h0;
	logic        pll_n = 1'h1;
	logic        k, kn, sel_n, rnw, oe_n, vld, echo, echo_n, wrdy;
	logic [7:0]  addr;
	logic [3:0]  lane_sel_n;
	logic [35:0] dq, q;
	int          n_mismatch = 0;
	int          checked = 0;
	int          cyc = 0;
	initial forever #10 clk_in = ~clk_in;
	ddr_burst2_sram_port #(.DATA_W(36), .ADDR_W(8)) dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .k_in(k),
		.k_n_in(kn), .cycle_select_n_in(sel_n), .read_not_write_in(rnw), .pll_disable_n_in(pll_n),
		.addr_in(addr), .byte_write_sel_n_in(lane_sel_n), .dq_in(dq), .dq_out(q), .dq_oe_n_out(oe_n),
		.out_valid_flag_out(vld), .echo_strobe_out(echo), .echo_strobe_n_out(echo_n), .wbuf_ready_out(wrdy));
	dbp_ctrl_model ctrl_u (.clk_in(clk_in), .q_in(q), .q_oe_n_in(oe_n), .k_out(k), .k_n_out(kn),
		.sel_n_out(sel_n), .rnw_out(rnw), .addr_out(addr), .lane_sel_n_out(lane_sel_n), .dq_out(dq));
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'h1) begin
			n_mismatch++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic final_report;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// waits from the command's end, then samples each word mid-stand
	task automatic collect(input int n, lo, hi, input logic [35:0] e [4]);
		int t;
		t = 0;
		ctrl_u.at_ph(3'h1);
		while (vld !== 1'h1 && t < 40) begin
			@(posedge clk_in);
			t++;
		end
		chk(t >= lo && t <= hi, "read latency");
		for (int i = 0; i < n; i++) begin
			repeat (i == 0 ? 2 : 4) @(posedge clk_in);
			chk(q === e[i] && vld === 1'h1 && oe_n === 1'h0, "read word");
		end
		repeat (4) @(posedge clk_in);
		chk(vld === 1'h0 && oe_n === 1'h1, "bus not released");
	endtask
	task automatic t_lanes;
		logic [35:0] m0, m1;
		for (int n = 0; n < 4; n++) begin
			m0 = 36'h1ff << (9 * n);
			m1 = 36'h1ff << (9 * (3 - n));
			ctrl_u.cycle(1'h1, 1'h0, n[7:0], A0, A1, 4'h0, 4'h0);
			ctrl_u.cycle(1'h1, 1'h0, n[7:0], ~A0, ~A1, ~(4'h1 << n), ~(4'h8 >> n));
			fork
				ctrl_u.cycle(1'h1, 1'h1, n[7:0], 36'h0, 36'h0, 4'hf, 4'hf);
				collect(2, 15, 21, '{A0 ^ m0, A1 ^ m1, 36'h0, 36'h0});
			join
		end
	endtask
	task automatic t_b2b;
		pll_n <= 1'h0;
		ctrl_u.idle;
		ctrl_u.idle;
		fork
			begin
				ctrl_u.cycle(1'h1, 1'h1, 8'h0, 36'h0, 36'h0, 4'hf, 4'hf);
				ctrl_u.cycle(1'h1, 1'h1, 8'h3, 36'h0, 36'h0, 4'hf, 4'hf);
			end
			collect(4, 7, 13, '{A0 ^ 36'h1ff, A1 ^ (36'h1ff << 27), A0 ^ (36'h1ff << 27), A1 ^ 36'h1ff});
		join
	endtask
	task automatic t_echo;
		int t;
		t = 0;
		@(posedge k);
		while (echo !== 1'h1 && t < 8) begin
			@(posedge clk_in);
			t++;
		end
		chk(t >= 2 && t <= 4 && echo_n === 1'h0, "echo strobe");
	endtask
	initial begin
		repeat (10) @(posedge clk_in);
		rst_b_in <= 1'h1;
		repeat (4) @(posedge clk_in);
		chk(oe_n === 1'h1 && vld === 1'h0 && wrdy === 1'h1, "reset state");
		ctrl_u.idle;
		t_lanes;
		t_b2b;
		t_echo;
		final_report;
	end
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			final_report;
		end
	end
endmodule
`default_nettype wire
